// file: core/rsa_pkg.sv
// Shared constants and types for the rotate, subtract and skip datapath.
package rsa_pkg;
    // ==========================================================
    // Register map, byte addresses on the register bus.
    localparam logic [7:0] RSA_OFS_CTRL = 8'h00;
    localparam logic [7:0] RSA_OFS_OPERAND = 8'h04;
    localparam logic [7:0] RSA_OFS_ACC = 8'h08;
    localparam logic [7:0] RSA_OFS_FLAGS = 8'h0c;
    localparam logic [7:0] RSA_OFS_STATUS = 8'h10;
    // ==========================================================
    // Field positions.
    localparam int RSA_CTRL_GO_BIT = 8;
    localparam int RSA_FLAG_C = 0;
    localparam int RSA_FLAG_AC = 1;
    localparam int RSA_FLAG_Z = 2;
    localparam int RSA_FLAG_OV = 3;
    localparam int RSA_STAT_BUSY = 0;
    localparam int RSA_STAT_SKIP = 1;
    localparam int RSA_STAT_DUMMY = 2;
    // ==========================================================
    // Reset values.
    localparam logic [2:0] RSA_RST_OP = 3'h0;
    localparam logic [7:0] RSA_RST_BYTE = 8'h00;
    localparam logic [3:0] RSA_RST_FLAGS = 4'h0;
    // ==========================================================
    // Operation codes written to the control register.
    typedef logic [2:0] rsa_op_t;
    localparam rsa_op_t RSA_OP_ROTATE_RIGHT_TO_ACCUM = 3'h0;
    localparam rsa_op_t RSA_OP_ROTATE_RIGHT_THRU_CARRY = 3'h1;
    localparam rsa_op_t RSA_OP_ROTATE_RIGHT_THRU_CARRY_TO_ACCUM = 3'h2;
    localparam rsa_op_t RSA_OP_SUBTRACT_BORROW_TO_ACCUM = 3'h3;
    localparam rsa_op_t RSA_OP_SUBTRACT_BORROW_TO_MEMORY = 3'h4;
    localparam rsa_op_t RSA_OP_DECREMENT_SKIP_IF_ZERO = 3'h5;
endpackage

// file: core/rsa_ops_if.sv
// Interface joining the register front end, the operation unit and the sequencer.
`timescale 1ns/1ps
`default_nettype none
interface rsa_ops_if;
    import rsa_pkg::*;
    rsa_op_t op;
    logic [7:0] acc;
    logic [7:0] mem;
    logic [3:0] flags;
    logic [7:0] result;
    logic wr_acc;
    logic wr_mem;
    logic [3:0] flags_new;
    logic skip;
    logic start;
    logic exec;
    logic dummy;
    logic busy;
    modport core (output op, acc, mem, flags, start,
                  input result, wr_acc, wr_mem, flags_new, skip, exec, dummy, busy);
    modport alu (input op, acc, mem, flags,
                 output result, wr_acc, wr_mem, flags_new, skip);
    modport seq (input start, skip, output exec, dummy, busy);
endinterface
`default_nettype wire

// file: core/rsa_alu.sv
// Combinational operation unit for rotates, subtract with borrow and decrement.
`timescale 1ns/1ps
`default_nettype none
module rsa_alu (
    rsa_ops_if.alu ops
);
    import rsa_pkg::*;
    logic [8:0] diff;
    logic [4:0] low;
    logic [7:0] dec;
    logic c_in;
    always_comb begin
        c_in = ops.flags[RSA_FLAG_C];
        diff = {1'b0, ops.acc} - {1'b0, ops.mem} - {8'h00, ~c_in};
        low = {1'b0, ops.acc[3:0]} - {1'b0, ops.mem[3:0]} - {4'h0, ~c_in};
        dec = ops.mem - 8'h01;
        ops.result = ops.mem;
        ops.wr_acc = 1'b0;
        ops.wr_mem = 1'b0;
        ops.flags_new = ops.flags;
        ops.skip = 1'b0;
        unique case (ops.op)
            RSA_OP_ROTATE_RIGHT_TO_ACCUM: begin
                ops.result = {ops.mem[0], ops.mem[7:1]};
                ops.wr_acc = 1'b1;
            end
            RSA_OP_ROTATE_RIGHT_THRU_CARRY: begin
                ops.result = {c_in, ops.mem[7:1]};
                ops.wr_mem = 1'b1;
                ops.flags_new[RSA_FLAG_C] = ops.mem[0];
            end
            RSA_OP_ROTATE_RIGHT_THRU_CARRY_TO_ACCUM: begin
                ops.result = {c_in, ops.mem[7:1]};
                ops.wr_acc = 1'b1;
                ops.flags_new[RSA_FLAG_C] = ops.mem[0];
            end
            RSA_OP_SUBTRACT_BORROW_TO_ACCUM, RSA_OP_SUBTRACT_BORROW_TO_MEMORY: begin
                ops.result = diff[7:0];
                ops.wr_acc = (ops.op == RSA_OP_SUBTRACT_BORROW_TO_ACCUM);
                ops.wr_mem = (ops.op == RSA_OP_SUBTRACT_BORROW_TO_MEMORY);
                ops.flags_new[RSA_FLAG_C] = ~diff[8];
                ops.flags_new[RSA_FLAG_AC] = ~low[4];
                ops.flags_new[RSA_FLAG_Z] = (diff[7:0] == 8'h00);
                ops.flags_new[RSA_FLAG_OV] = (ops.acc[7] ^ ops.mem[7])
                    & (ops.acc[7] ^ diff[7]);
            end
            RSA_OP_DECREMENT_SKIP_IF_ZERO: begin
                ops.result = dec;
                ops.wr_mem = 1'b1;
                ops.skip = (dec == 8'h00);
            end
            default: begin
                ops.result = ops.mem;
            end
        endcase
    end
endmodule
`default_nettype wire

// file: core/rsa_seq.sv
// Instruction cycle sequencer with the dummy cycle for a taken skip.
`timescale 1ns/1ps
`default_nettype none
module rsa_seq (
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    rsa_ops_if.seq ops
);
    import rsa_pkg::*;
    typedef enum logic [1:0] {RSA_IDLE, RSA_EXEC, RSA_DUMMY} rsa_phase_t;
    typedef struct packed {
        rsa_phase_t phase;
    } rsa_seq_state_t;
    rsa_seq_state_t s_q;
    rsa_seq_state_t s_d;
    // ==========================================================
    // Phase sequencing.
    always_comb begin
        s_d = s_q;
        unique case (s_q.phase)
            RSA_IDLE: begin
                if (ops.start) begin
                    s_d.phase = RSA_EXEC;
                end
            end
            RSA_EXEC: begin
                s_d.phase = ops.skip ? RSA_DUMMY : RSA_IDLE;
            end
            RSA_DUMMY: begin
                s_d.phase = RSA_IDLE;
            end
            default: begin
                s_d.phase = RSA_IDLE;
            end
        endcase
    end
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s_q.phase <= RSA_IDLE;
        end else begin
            s_q <= s_d;
        end
    end
    assign ops.exec = (s_q.phase == RSA_EXEC);
    assign ops.dummy = (s_q.phase == RSA_DUMMY);
    assign ops.busy = (s_q.phase != RSA_IDLE);
endmodule
`default_nettype wire

// file: core/rsa_top.sv
// Rotate, subtract with borrow and decrement-skip datapath with a Wishbone register port.
//
// Notes on behaviour
// - Rotate right to accumulator: bit 0 goes to bit 7, memory and flags kept.
// - Rotate right through carry to memory: carry into bit 7, bit 0 into carry.
// - Rotate right through carry to accumulator: memory kept, carry takes bit 0.
// - Subtract with borrow to accumulator updates accumulator and four flags.
// - Subtract with borrow to memory writes memory, accumulator kept, same flags.
// - After subtraction carry is clear when negative, set when zero or positive.
// - Decrement memory by one, write back, skip next instruction when zero.
// - A taken skip inserts one dummy cycle, making two instruction cycles.
// - A nonzero result continues normally with no dummy cycle.
//
// Chosen here: the address map and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module rsa_top (
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    output logic [7:0] o_acc,
    output logic [7:0] o_mem_data,
    output logic o_mem_we,
    output logic [3:0] o_flags,
    output logic o_skip,
    output logic o_dummy_cycle
);
    import rsa_pkg::*;

    // ==========================================================
    // State.
    typedef struct packed {
        logic ack;
        logic [31:0] rdat;
        rsa_op_t op;
        logic start;
        logic [7:0] acc;
        logic [7:0] mem;
        logic [3:0] flags;
        logic mem_we;
        logic skip;
        logic skip_seen;
        logic dummy;
    } rsa_top_state_t;

    rsa_top_state_t s_q;
    rsa_top_state_t s_d;
    rsa_ops_if ops ();

    // ==========================================================
    // Byte merge helper for partial writes.
    function automatic logic [7:0] rsa_merge(input logic [7:0] old, input logic [7:0] wr,
                                             input logic en);
        rsa_merge = en ? wr : old;
    endfunction

    // ==========================================================
    // Submodules.
    rsa_alu u_alu (
        .ops(ops.alu)
    );

    rsa_seq u_seq (
        .i_core_clk(i_core_clk),
        .i_reset_n(i_reset_n),
        .ops(ops.seq)
    );

    assign ops.op = s_q.op;
    assign ops.acc = s_q.acc;
    assign ops.mem = s_q.mem;
    assign ops.flags = s_q.flags;
    assign ops.start = s_q.start;

    // ==========================================================
    // Bus access and operation commit.
    logic req;
    logic wr;
    logic [31:0] status_word;

    always_comb begin
        req = i_wb_cyc & i_wb_stb & ~s_q.ack;
        wr = req & i_wb_we;
        status_word = 32'h00000000;
        status_word[RSA_STAT_BUSY] = ops.busy;
        status_word[RSA_STAT_SKIP] = s_q.skip_seen;
        status_word[RSA_STAT_DUMMY] = ops.dummy;
        s_d = s_q;
        s_d.ack = req;
        s_d.start = 1'b0;
        s_d.mem_we = 1'b0;
        s_d.skip = 1'b0;
        s_d.dummy = ops.dummy;
        if (req) begin
            unique case (i_wb_adr)
                RSA_OFS_CTRL: begin
                    s_d.rdat = {29'h00000000, s_q.op};
                end
                RSA_OFS_OPERAND: begin
                    s_d.rdat = {24'h000000, s_q.mem};
                end
                RSA_OFS_ACC: begin
                    s_d.rdat = {24'h000000, s_q.acc};
                end
                RSA_OFS_FLAGS: begin
                    s_d.rdat = {28'h0000000, s_q.flags};
                end
                RSA_OFS_STATUS: begin
                    s_d.rdat = status_word;
                end
                default: begin
                    s_d.rdat = 32'h00000000;
                end
            endcase
        end
        if (wr && !ops.busy) begin
            unique case (i_wb_adr)
                RSA_OFS_CTRL: begin
                    if (i_wb_sel[0]) begin
                        s_d.op = i_wb_dat[2:0];
                    end
                    if (i_wb_sel[1] && i_wb_dat[RSA_CTRL_GO_BIT]) begin
                        s_d.start = 1'b1;
                        s_d.skip_seen = 1'b0;
                    end
                end
                RSA_OFS_OPERAND: begin
                    s_d.mem = rsa_merge(s_q.mem, i_wb_dat[7:0], i_wb_sel[0]);
                end
                RSA_OFS_ACC: begin
                    s_d.acc = rsa_merge(s_q.acc, i_wb_dat[7:0], i_wb_sel[0]);
                end
                RSA_OFS_FLAGS: begin
                    if (i_wb_sel[0]) begin
                        s_d.flags = i_wb_dat[3:0];
                    end
                end
                default: begin
                    s_d.rdat = s_d.rdat;
                end
            endcase
        end
        if (ops.exec) begin
            if (ops.wr_acc) begin
                s_d.acc = ops.result;
            end
            if (ops.wr_mem) begin
                s_d.mem = ops.result;
                s_d.mem_we = 1'b1;
            end
            s_d.flags = ops.flags_new;
            s_d.skip = ops.skip;
            s_d.skip_seen = ops.skip;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s_q.ack <= 1'b0;
            s_q.rdat <= 32'h00000000;
            s_q.op <= RSA_RST_OP;
            s_q.start <= 1'b0;
            s_q.acc <= RSA_RST_BYTE;
            s_q.mem <= RSA_RST_BYTE;
            s_q.flags <= RSA_RST_FLAGS;
            s_q.mem_we <= 1'b0;
            s_q.skip <= 1'b0;
            s_q.skip_seen <= 1'b0;
            s_q.dummy <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // Outputs.
    assign o_wb_ack = s_q.ack;
    assign o_wb_dat = s_q.rdat;
    assign o_acc = s_q.acc;
    assign o_mem_data = s_q.mem;
    assign o_mem_we = s_q.mem_we;
    assign o_flags = s_q.flags;
    assign o_skip = s_q.skip;
    assign o_dummy_cycle = s_q.dummy;
endmodule
`default_nettype wire

// file: verif/rsa_top_asserts.sv
// Concurrent checks on the ports of the rotate, subtract and skip datapath.
`timescale 1ns/1ps
`default_nettype none
module rsa_top_asserts (
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic o_wb_ack,
    input wire logic [7:0] o_acc,
    input wire logic [7:0] o_mem_data,
    input wire logic o_mem_we,
    input wire logic o_skip,
    input wire logic o_dummy_cycle
);
    // ==========================================================
    // Checks.
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);
    sequence s_zero_write;
        o_mem_we && (o_mem_data == 8'h00);
    endsequence
    sequence s_dummy;
        o_dummy_cycle ##1 !o_dummy_cycle;
    endsequence
    AST_SKIP_ZERO: assert property (o_skip |-> s_zero_write)
        else $error("skip without a zero write");
    AST_DUMMY_AFTER: assert property (o_skip |=> s_dummy)
        else $error("no single dummy cycle after skip");
    AST_DUMMY_CAUSE: assert property (o_dummy_cycle |-> $past(o_skip))
        else $error("dummy cycle without skip");
    AST_NONZERO_GO_ON: assert property (o_mem_we && o_mem_data != 8'h00 |-> !o_skip)
        else $error("skip on nonzero value");
    AST_ACC_KEPT: assert property (o_mem_we |-> $stable(o_acc))
        else $error("accumulator moved on memory write");
    AST_MEM_CAUSE: assert property ($changed(o_mem_data) |-> o_mem_we || o_wb_ack && i_wb_we)
        else $error("memory operand moved without a write");
    AST_MEM_WE_PULSE: assert property (o_mem_we |=> !o_mem_we)
        else $error("memory write strobe too long");
    AST_ACK_PULSE: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack longer than one cycle");
    AST_ACK_CAUSE: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
        else $error("ack without request");
endmodule
bind rsa_top rsa_top_asserts u_asserts (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
    .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .o_wb_ack(o_wb_ack),
    .o_acc(o_acc), .o_mem_data(o_mem_data), .o_mem_we(o_mem_we), .o_skip(o_skip),
    .o_dummy_cycle(o_dummy_cycle));
`default_nettype wire

// file: verif/rsa_top_test.sv
// Self-checking bench for the rotate, subtract and skip datapath.
`timescale 1ns/1ps
`default_nettype none
module rsa_top_test;
    import rsa_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0, rdat;
    logic ack, mwe, skp, dmy;
    logic [7:0] acc, mem;
    logic [3:0] flg;
    int failures = 0, tests_run = 0, cycles = 0, n_skip = 0, n_dummy = 0, n_mwe = 0;
    logic [31:0] q;
    rsa_top dut (.i_core_clk(clk), .i_reset_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hf), .i_wb_dat(dat), .o_wb_dat(rdat),
        .o_wb_ack(ack), .o_acc(acc), .o_mem_data(mem), .o_mem_we(mwe), .o_flags(flg),
        .o_skip(skp), .o_dummy_cycle(dmy));
    // ==========================================================
    // Clock, timeout and pulse counters.
    initial begin
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (skp === 1'b1) n_skip++;
        if (dmy === 1'b1) n_dummy++;
        if (mwe === 1'b1) n_mwe++;
        if (cycles == 20000) begin
            failures++;
            finish_test();
        end
    end
    // ==========================================================
    // Tasks.
    task automatic finish_test();
        $display("failures=%0d tests_run=%0d", failures, tests_run);
        if (failures == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    function automatic logic [20:0] exp_op(rsa_op_t op, logic [7:0] a, m, logic [3:0] f);
        logic [8:0] r;
        logic [4:0] h;
        logic [7:0] na, nm;
        logic [3:0] nf;
        logic s;
        na = a;
        nm = m;
        nf = f;
        s = 1'b0;
        r = {1'b0, a} - {1'b0, m} - {8'h00, ~f[0]};
        h = {1'b0, a[3:0]} - {1'b0, m[3:0]} - {4'h0, ~f[0]};
        case (op)
            RSA_OP_ROTATE_RIGHT_TO_ACCUM: na = {m[0], m[7:1]};
            RSA_OP_ROTATE_RIGHT_THRU_CARRY: begin
                nm = {f[0], m[7:1]};
                nf[0] = m[0];
            end
            RSA_OP_ROTATE_RIGHT_THRU_CARRY_TO_ACCUM: begin
                na = {f[0], m[7:1]};
                nf[0] = m[0];
            end
            RSA_OP_SUBTRACT_BORROW_TO_ACCUM, RSA_OP_SUBTRACT_BORROW_TO_MEMORY: begin
                nf = {(a[7] ^ m[7]) & (a[7] ^ r[7]), r[7:0] == 8'h00, ~h[4], ~r[8]};
                if (op == RSA_OP_SUBTRACT_BORROW_TO_ACCUM) na = r[7:0];
                else nm = r[7:0];
            end
            RSA_OP_DECREMENT_SKIP_IF_ZERO: begin
                nm = m - 8'h01;
                s = (nm == 8'h00);
            end
            default: ;
        endcase
        return {s, nf, nm, na};
    endfunction
    task automatic run(input rsa_op_t op, input logic [7:0] a, m, input logic [3:0] f);
        logic [20:0] e;
        logic mw;
        e = exp_op(op, a, m, f);
        mw = (op == RSA_OP_ROTATE_RIGHT_THRU_CARRY) || (op == RSA_OP_SUBTRACT_BORROW_TO_MEMORY)
            || (op == RSA_OP_DECREMENT_SKIP_IF_ZERO);
        wb(1'b1, RSA_OFS_ACC, {24'h0, a});
        wb(1'b1, RSA_OFS_OPERAND, {24'h0, m});
        wb(1'b1, RSA_OFS_FLAGS, {28'h0, f});
        n_skip = 0;
        n_dummy = 0;
        n_mwe = 0;
        wb(1'b1, RSA_OFS_CTRL, {23'h0, 1'b1, 5'h0, op});
        do wb(1'b0, RSA_OFS_STATUS, 32'h0); while (q[RSA_STAT_BUSY] !== 1'b0);
        chk(q, {30'h0, e[20], 1'b0});
        wb(1'b0, RSA_OFS_ACC, 32'h0);
        chk(q, {24'h0, e[7:0]});
        wb(1'b0, RSA_OFS_OPERAND, 32'h0);
        chk(q, {24'h0, e[15:8]});
        wb(1'b0, RSA_OFS_FLAGS, 32'h0);
        chk(q, {28'h0, e[19:16]});
        chk({flg, mem, acc}, {e[19:16], e[15:8], e[7:0]});
        chk(n_skip, {31'h0, e[20]});
        chk(n_dummy, {31'h0, e[20]});
        chk(n_mwe, {31'h0, mw});
    endtask
    // ==========================================================
    // Main sequence.
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            wb(1'b0, 8'(i * 4), 32'h0);
            chk(q, 32'h0);
        end
        run(3'h0, 8'h5a, 8'h81, 4'ha);
        run(3'h1, 8'h00, 8'h81, 4'h0);
        run(3'h1, 8'h00, 8'h02, 4'h1);
        run(3'h2, 8'h33, 8'h01, 4'h0);
        run(3'h3, 8'h10, 8'h01, 4'h1);
        run(3'h3, 8'h80, 8'h01, 4'h1);
        run(3'h3, 8'h05, 8'h05, 4'h0);
        run(3'h3, 8'h05, 8'h04, 4'h0);
        run(3'h4, 8'h01, 8'h02, 4'h1);
        run(3'h5, 8'h77, 8'h01, 4'h0);
        run(3'h5, 8'h77, 8'h00, 4'h0);
        run(3'h5, 8'h77, 8'h02, 4'h5);
        run(3'h6, 8'h12, 8'h34, 4'h5);
        // A write that lands during the dummy phase is acknowledged but ignored.
        wb(1'b1, RSA_OFS_ACC, 32'h11);
        wb(1'b1, RSA_OFS_OPERAND, 32'h01);
        wb(1'b1, RSA_OFS_CTRL, {23'h0, 1'b1, 5'h0, RSA_OP_DECREMENT_SKIP_IF_ZERO});
        wb(1'b1, RSA_OFS_ACC, 32'h99);
        wb(1'b0, RSA_OFS_ACC, 32'h0);
        chk(q, 32'h11);
        wb(1'b0, RSA_OFS_OPERAND, 32'h0);
        chk(q, 32'h0);
        // A reset in mid-run clears every register again.
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        wb(1'b0, RSA_OFS_FLAGS, 32'h0);
        chk(q, 32'h0);
        chk({flg, mem, acc}, 32'h0);
        finish_test();
    end
endmodule
`default_nettype wire
